// >>> flash_host_consts.vh
// Constants for the dual-bank flash host controller.
`ifndef FLASH_HOST_CONSTS_VH
`define FLASH_HOST_CONSTS_VH
`define ADDR_W          20
`define DATA_W          16
`define UNLOCK_ADDR1    20'h05555
`define UNLOCK_ADDR2    20'h02AAA
`define UNLOCK_DATA1    16'h00AA
`define UNLOCK_DATA2    16'h0055
`define CMD_PROGRAM     16'h00A0
`define CMD_ERASE_SETUP 16'h0080
`define CMD_SECTOR_ERS  16'h0030
`define CMD_BLOCK_ERS   16'h0050
`define CMD_CHIP_ERS    16'h0010
`define OP_READ         3'h0
`define OP_PROGRAM      3'h1
`define OP_SECTOR_ERS   3'h2
`define OP_BLOCK_ERS    3'h3
`define OP_CHIP_ERS     3'h4
`define POLL_BIT        7
`define TOGGLE_BIT      6
`define CLK_MHZ         40
`define T_SETUP_NS      25
`define T_PULSE_NS      50
`define T_ACCESS_NS     70
`define T_RECOVERY_NS   1000
`define T_SETUP_CYC     ((`T_SETUP_NS * `CLK_MHZ + 999) / 1000)
`define T_PULSE_CYC     ((`T_PULSE_NS * `CLK_MHZ + 999) / 1000)
`define T_ACCESS_CYC    ((`T_ACCESS_NS * `CLK_MHZ + 999) / 1000)
`define T_RECOVERY_CYC  ((`T_RECOVERY_NS * `CLK_MHZ + 999) / 1000)
`define SEQ_LAST        3'h5
`define CNT_W           6
`endif

// >>> flash_seq_rom.v
// Command sequence table: address and data of each bus cycle, registered output.
`default_nettype none
`include "flash_host_consts.vh"
module flash_seq_rom (
  input  wire                 clk,
  input  wire                 rst,
  input  wire [2:0]           op,
  input  wire [2:0]           step,
  input  wire [`ADDR_W-1:0]   user_addr,
  input  wire [`DATA_W-1:0]   user_data,
  output reg  [`ADDR_W-1:0]   seq_addr_reg,
  output reg  [`DATA_W-1:0]   seq_data_reg
);
  reg [`ADDR_W-1:0] a_next;
  reg [`DATA_W-1:0] d_next;
  always @* begin
    a_next = `UNLOCK_ADDR1;
    d_next = `UNLOCK_DATA1;
    case (step)
      3'h1: begin
        a_next = `UNLOCK_ADDR2;
        d_next = `UNLOCK_DATA2;
      end
      3'h2: begin
        a_next = `UNLOCK_ADDR1;
        d_next = (op == `OP_PROGRAM) ? `CMD_PROGRAM : `CMD_ERASE_SETUP;
      end
      3'h3: begin
        a_next = (op == `OP_PROGRAM) ? user_addr : `UNLOCK_ADDR1;
        d_next = (op == `OP_PROGRAM) ? user_data : `UNLOCK_DATA1;
      end
      3'h4: begin
        a_next = `UNLOCK_ADDR2;
        d_next = `UNLOCK_DATA2;
      end
      3'h5: begin
        a_next = (op == `OP_CHIP_ERS) ? `UNLOCK_ADDR1 : user_addr;
        d_next = (op == `OP_SECTOR_ERS) ? `CMD_SECTOR_ERS :
                 (op == `OP_BLOCK_ERS) ? `CMD_BLOCK_ERS : `CMD_CHIP_ERS;
      end
      default: begin
        a_next = `UNLOCK_ADDR1;
        d_next = `UNLOCK_DATA1;
      end
    endcase
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      seq_addr_reg <= 20'h00000;
      seq_data_reg <= 16'h0000;
    end else begin
      seq_addr_reg <= a_next;
      seq_data_reg <= d_next;
    end
  end
endmodule
`default_nettype wire

// >>> flash_host.v
// Host controller that drives a dual-bank parallel flash through its pins.
`default_nettype none
`include "flash_host_consts.vh"
// Overview of operation
// - Each command cycle pulses the write strobe low while chip select is low.
// - Host software must erase the sector before programming a word in it.
// - Program is three unlock cycles, then one address and data cycle.
// - Sector erase is six cycles ending with code 30H at the sector address.
// - Block erase is six cycles ending with code 50H at the block address.
// - Chip erase is six cycles ending with 10H written to 5555H.
// - On apparent completion, re-read twice more; both must match to finish.
module flash_host (
  input  wire                 clk,
  input  wire                 rst,
  input  wire                 req_valid,
  input  wire [2:0]           req_op,
  input  wire [`ADDR_W-1:0]   req_addr,
  input  wire [`DATA_W-1:0]   req_data,
  output reg                  req_ready_reg,
  output reg                  done_reg,
  output reg  [`DATA_W-1:0]   rd_data_reg,
  output reg                  write_busy_reg,
  output reg  [`ADDR_W-1:0]   flash_addr_reg,
  output reg                  flash_ce_n_reg,
  output reg                  flash_we_n_reg,
  output reg                  flash_oe_n_reg,
  output reg  [`DATA_W-1:0]   flash_dq_out_reg,
  output reg                  flash_dq_oe_n_reg,
  input  wire [`DATA_W-1:0]   flash_dq_in,
  input  wire                 busy_output_pin
);
  localparam S_IDLE  = 3'h0;
  localparam S_SETUP = 3'h1;
  localparam S_PULSE = 3'h2;
  localparam S_HOLD  = 3'h3;
  localparam S_READ  = 3'h4;
  localparam S_POLL  = 3'h5;
  localparam S_GAP   = 3'h6;
  localparam integer      SETUP_CYC = `T_SETUP_CYC;
  localparam integer      PULSE_CYC = `T_PULSE_CYC;
  localparam integer      ACC_CYC   = `T_ACCESS_CYC;
  localparam [`CNT_W-1:0] C_SETUP   = SETUP_CYC[`CNT_W-1:0];
  localparam [`CNT_W-1:0] C_PULSE   = PULSE_CYC[`CNT_W-1:0];
  localparam [`CNT_W-1:0] C_ACC     = ACC_CYC[`CNT_W-1:0];
  localparam [`CNT_W-1:0] C_ONE     = 6'h01;

  reg [2:0]          state_reg;
  reg [2:0]          op_reg;
  reg [2:0]          step_reg;
  reg [`CNT_W-1:0]   cnt_reg;
  reg [`ADDR_W-1:0]  addr_reg;
  reg [`DATA_W-1:0]  data_reg;
  reg [1:0]          match_reg;
  reg                toggle_seen_reg;
  reg                toggle_prev_reg;
  reg [2:0]          busy_sync_reg;
  reg                busy_low_reg;
  wire [`ADDR_W-1:0] seq_addr;
  wire [`DATA_W-1:0] seq_data;
  wire               status_ok;

  flash_seq_rom u_rom (
    .clk          (clk),
    .rst          (rst),
    .op           (op_reg),
    .step         (step_reg),
    .user_addr    (addr_reg),
    .user_data    (data_reg),
    .seq_addr_reg (seq_addr),
    .seq_data_reg (seq_data)
  );

  // Completion needs true data on the polling bit and a still toggle bit.
  // A word that was not erased first reads back old AND new data, so its write completes only if that equals the new data.
  assign status_ok = (op_reg == `OP_PROGRAM) ?
                     (flash_dq_in == data_reg) :
                     (flash_dq_in[`POLL_BIT] == 1'b1);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_sync_reg <= 3'h7;
      busy_low_reg  <= 1'b0;
    end else begin
      busy_sync_reg <= {busy_sync_reg[1:0], busy_output_pin};
      // Busy pin is asynchronous; a change counts once the two later stages agree.
      if (busy_sync_reg[2] == busy_sync_reg[1]) begin
        busy_low_reg <= ~busy_sync_reg[2];
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg         <= S_IDLE;
      op_reg            <= `OP_READ;
      step_reg          <= 3'h0;
      cnt_reg           <= 6'h00;
      addr_reg          <= 20'h00000;
      data_reg          <= 16'h0000;
      match_reg         <= 2'h0;
      toggle_seen_reg   <= 1'b0;
      toggle_prev_reg   <= 1'b0;
      req_ready_reg     <= 1'b0;
      done_reg          <= 1'b0;
      rd_data_reg       <= 16'h0000;
      write_busy_reg    <= 1'b0;
      flash_addr_reg    <= 20'h00000;
      flash_ce_n_reg    <= 1'b1;
      flash_we_n_reg    <= 1'b1;
      flash_oe_n_reg    <= 1'b1;
      flash_dq_out_reg  <= 16'h0000;
      flash_dq_oe_n_reg <= 1'b1;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          flash_ce_n_reg    <= 1'b1;
          flash_oe_n_reg    <= 1'b1;
          flash_we_n_reg    <= 1'b1;
          flash_dq_oe_n_reg <= 1'b1;
          // A write waits for the busy pin; reads skip that check, but no request is taken until a write's polling ends.
          req_ready_reg     <= 1'b1;
          if (req_valid && req_ready_reg &&
              !(req_op != `OP_READ && (write_busy_reg || busy_low_reg))) begin
            req_ready_reg <= 1'b0;
            op_reg        <= req_op;
            addr_reg      <= req_addr;
            data_reg      <= req_data;
            step_reg      <= 3'h0;
            cnt_reg       <= C_ONE;
            if (req_op == `OP_READ) begin
              flash_addr_reg <= req_addr;
              state_reg      <= S_READ;
            end else begin
              state_reg <= S_SETUP;
            end
          end else if (req_valid && req_ready_reg) begin
            req_ready_reg <= 1'b0;
          end
        end
        S_SETUP: begin
          // The table answers one edge after the step moves, so the first edge here
          // drives a stale word; the strobe falls a full setup time after the fresh one.
          flash_addr_reg    <= seq_addr;
          flash_dq_out_reg  <= seq_data;
          flash_dq_oe_n_reg <= 1'b0;
          flash_ce_n_reg    <= 1'b0;
          if (cnt_reg > C_SETUP + C_ONE) begin
            cnt_reg        <= C_ONE;
            flash_we_n_reg <= 1'b0;
            state_reg      <= S_PULSE;
          end else begin
            cnt_reg <= cnt_reg + C_ONE;
          end
        end
        S_PULSE: begin
          if (cnt_reg >= C_PULSE) begin
            cnt_reg        <= C_ONE;
            flash_we_n_reg <= 1'b1;
            state_reg      <= S_HOLD;
          end else begin
            cnt_reg <= cnt_reg + C_ONE;
          end
        end
        S_HOLD: begin
          // Data and select stay one cycle past the rise so the latch sees it stable.
          flash_ce_n_reg    <= 1'b1;
          flash_dq_oe_n_reg <= 1'b1;
          cnt_reg           <= C_ONE;
          if ((op_reg == `OP_PROGRAM && step_reg == 3'h3) ||
              step_reg == `SEQ_LAST) begin
            write_busy_reg  <= 1'b1;
            match_reg       <= 2'h0;
            toggle_seen_reg <= 1'b0;
            state_reg       <= S_GAP;
          end else begin
            step_reg  <= step_reg + 3'h1;
            state_reg <= S_SETUP;
          end
        end
        S_GAP: begin
          flash_ce_n_reg <= 1'b1;
          flash_oe_n_reg <= 1'b1;
          if (cnt_reg >= C_ACC) begin
            cnt_reg        <= C_ONE;
            flash_addr_reg <= addr_reg;
            state_reg      <= S_POLL;
          end else begin
            cnt_reg <= cnt_reg + C_ONE;
          end
        end
        S_POLL: begin
          flash_ce_n_reg    <= 1'b0;
          flash_oe_n_reg    <= 1'b0;
          flash_dq_oe_n_reg <= 1'b1;
          if (cnt_reg > C_ACC) begin
            cnt_reg         <= C_ONE;
            flash_ce_n_reg  <= 1'b1;
            flash_oe_n_reg  <= 1'b1;
            toggle_prev_reg <= flash_dq_in[`TOGGLE_BIT];
            toggle_seen_reg <= 1'b1;
            // Status read may race completion, so two further matches confirm it.
            if (status_ok && !busy_low_reg && (!toggle_seen_reg ||
                toggle_prev_reg == flash_dq_in[`TOGGLE_BIT])) begin
              match_reg <= match_reg + 2'h1;
              state_reg <= S_GAP;
              if (match_reg == 2'h2) begin
                write_busy_reg <= 1'b0;
                done_reg       <= 1'b1;
                state_reg      <= S_IDLE;
              end
            end else begin
              match_reg <= 2'h0;
              state_reg <= S_GAP;
            end
          end else begin
            cnt_reg <= cnt_reg + C_ONE;
          end
        end
        S_READ: begin
          flash_ce_n_reg    <= 1'b0;
          flash_oe_n_reg    <= 1'b0;
          flash_dq_oe_n_reg <= 1'b1;
          if (cnt_reg > C_ACC) begin
            rd_data_reg    <= flash_dq_in;
            flash_ce_n_reg <= 1'b1;
            flash_oe_n_reg <= 1'b1;
            done_reg       <= 1'b1;
            state_reg      <= S_IDLE;
          end else begin
            cnt_reg <= cnt_reg + C_ONE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> flash_host_asserts.sv
// Concurrent checks on the flash host controller's pins and request handshake.
`default_nettype none
`include "flash_host_consts.vh"
module flash_host_asserts (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               req_valid,
  input wire logic               req_ready_reg,
  input wire logic               done_reg,
  input wire logic [`ADDR_W-1:0] flash_addr_reg,
  input wire logic               flash_ce_n_reg,
  input wire logic               flash_we_n_reg,
  input wire logic               flash_oe_n_reg,
  input wire logic [`DATA_W-1:0] flash_dq_out_reg,
  input wire logic               flash_dq_oe_n_reg,
  input wire logic               busy_output_pin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  strobe_select_a: assert property (
    !flash_we_n_reg |-> !flash_ce_n_reg && flash_oe_n_reg) else $error("Strobe without select.");
  addr_stable_a: assert property (
    !flash_we_n_reg |-> $stable(flash_addr_reg)) else $error("Address moved under strobe.");
  data_hold_a: assert property (
    $rose(flash_we_n_reg) |-> !flash_ce_n_reg && !flash_dq_oe_n_reg && $stable(flash_dq_out_reg))
    else $error("Data not held at strobe rise.");
  pulse_width_a: assert property (
    $fell(flash_we_n_reg) |=> !flash_we_n_reg ##1 flash_we_n_reg) else $error("Bad strobe width.");
  bus_release_a: assert property (
    !flash_oe_n_reg |-> flash_dq_oe_n_reg && flash_we_n_reg) else $error("Host drives during read.");
  read_access_a: assert property (
    $fell(flash_oe_n_reg) |-> (!flash_oe_n_reg && !flash_ce_n_reg) [*3])
    else $error("Read shorter than access time.");
  standby_idle_a: assert property (
    req_ready_reg |-> flash_ce_n_reg) else $error("Select low while idle.");
  busy_holds_a: assert property (
    !busy_output_pin [*4] |-> !done_reg) else $error("Completion while device busy.");
  done_pulse_a: assert property (
    done_reg |=> !done_reg) else $error("Done longer than one cycle.");
  take_ready_a: assert property (
    req_valid && req_ready_reg |=> !req_ready_reg) else $error("Ready stayed high after take.");
endmodule
bind flash_host flash_host_asserts chk_u (.clk(clk), .rst(rst), .req_valid(req_valid),
  .req_ready_reg(req_ready_reg), .done_reg(done_reg), .flash_addr_reg(flash_addr_reg),
  .flash_ce_n_reg(flash_ce_n_reg), .flash_we_n_reg(flash_we_n_reg),
  .flash_oe_n_reg(flash_oe_n_reg), .flash_dq_out_reg(flash_dq_out_reg),
  .flash_dq_oe_n_reg(flash_dq_oe_n_reg), .busy_output_pin(busy_output_pin));
`default_nettype wire

// >>> flash_dev_model.sv
// Behavioural dual-bank flash device answering the host's pins.
`default_nettype none
`include "flash_host_consts.vh"
module flash_dev_model #(
  parameter int          PROG_NS    = 2000,
  parameter int          ERASE_NS   = 5000,
  parameter logic [19:0] BANK_SPLIT = 20'h40000
) (
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [19:0] addr,
  input  wire logic [15:0] dq,
  output var  logic        dq_drv,
  output var  logic [15:0] dq_out,
  output var  logic        busy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [int];
  logic [19:0] lat_a, op_a;
  logic [15:0] op_d;
  logic [2:0]  op, step;
  logic        busy, tog, in_wr, bank_b;
  initial begin
    busy = 0; tog = 0; step = 0; in_wr = 0; op = 0; dq_out = 16'h0000;
  end
  assign dq_drv = !ce_n && !oe_n && we_n;
  assign busy_n = !busy;
  always @(negedge ce_n or negedge we_n) if (!ce_n && !we_n) begin
    in_wr = 1; lat_a = addr;
  end
  always @(posedge ce_n or posedge we_n) if (in_wr) begin
    in_wr = 0; cmd(lat_a, dq);
  end
  task automatic start(input logic [2:0] o, input logic [19:0] a, input logic [15:0] d);
    op = o; op_a = a; op_d = d; bank_b = a >= BANK_SPLIT; busy = 1;
  endtask
  task automatic cmd(input logic [19:0] a, input logic [15:0] d);
    logic u1, u2;
    u1 = a == 20'h05555;
    u2 = a == 20'h02AAA && d == 16'h0055;
    if (busy) return;
    case (step)
      3'd0, 3'd3: step = (u1 && d == 16'h00AA) ? step + 3'd1 : 3'd0;
      3'd1, 3'd4: step = u2 ? step + 3'd1 : 3'd0;
      3'd2: step = !u1 ? 3'd0 : d == 16'h00A0 ? 3'd6 : d == 16'h0080 ? 3'd3 : 3'd0;
      3'd6: begin start(3'd1, a, d); step = 0; end
      default: begin
        if (d == 16'h0030) start(3'd2, a, d);
        else if (d == 16'h0050) start(3'd3, a, d);
        else if (d == 16'h0010 && u1) start(3'd4, a, d);
        step = 0;
      end
    endcase
  endtask
  // Erases finish in microseconds here, not milliseconds, to keep the run short.
  always @(posedge busy) begin
    int ks[$];
    int sh;
    ks.delete();
    #(op == 3'd1 ? PROG_NS : ERASE_NS);
    sh = (op == 3'd2) ? 10 : 15;
    if (op == 3'd1) mem[op_a] = mem.exists(op_a) ? mem[op_a] & op_d : op_d;
    else if (op == 3'd4) mem.delete();
    else foreach (mem[k]) if ((k >> sh) == (op_a >> sh)) ks.push_back(k);
    foreach (ks[i]) mem.delete(ks[i]);
    busy = 0;
  end
  always @(negedge oe_n) if (!ce_n && busy) tog = ~tog;
  function automatic logic [15:0] rd_val(input logic [19:0] a);
    if (busy && (op == 3'd4 || (a >= BANK_SPLIT) == bank_b))
      return {op == 3'd1 ? ~op_d[15:7] : 9'h000, tog, op == 3'd1 ? ~op_d[5:0] : 6'h00};
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction
  // Data is scrambled until the access time has passed after any change.
  always @(ce_n or oe_n or addr or busy or tog) begin
    dq_out = ~dq_out;
    dq_out <= #(`T_ACCESS_NS) rd_val(addr);
  end
endmodule
`default_nettype wire

// >>> flash_host_tb.sv
// Self-checking bench for the dual-bank flash host controller.
`default_nettype none
`include "flash_host_consts.vh"
module flash_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk, rst, req_valid, req_ready, done, wbusy, wb_seen;
  logic               ce_n, we_n, oe_n, dq_oe_n, busy_n, dev_drv;
  logic [2:0]         req_op;
  logic [`ADDR_W-1:0] req_addr, faddr, sa;
  logic [`DATA_W-1:0] req_data, rd_data, dq_out, dq_in, dev_dq, last_dq, d1, d2, d3;
  logic [16:0]        exp_q[$];
  logic [16:0]        e;
  logic [31:0]        r;
  int                 fail_count, checked, cycles;
  flash_host dut_u (.clk(clk), .rst(rst), .req_valid(req_valid), .req_op(req_op),
    .req_addr(req_addr), .req_data(req_data), .req_ready_reg(req_ready), .done_reg(done),
    .rd_data_reg(rd_data), .write_busy_reg(wbusy), .flash_addr_reg(faddr),
    .flash_ce_n_reg(ce_n), .flash_we_n_reg(we_n), .flash_oe_n_reg(oe_n),
    .flash_dq_out_reg(dq_out), .flash_dq_oe_n_reg(dq_oe_n), .flash_dq_in(dq_in),
    .busy_output_pin(busy_n));
  flash_dev_model dev_u (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(faddr), .dq(dq_in),
    .dq_drv(dev_drv), .dq_out(dev_dq), .busy_n(busy_n));
  // An undriven bus shows the inverse of its last level, so stale data never matches.
  assign dq_in = dev_drv ? dev_dq : !dq_oe_n ? dq_out : ~last_dq;
  always @(posedge clk) if (dev_drv || !dq_oe_n) last_dq <= dq_in;
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic req(input logic [2:0] o, input logic [19:0] a, input logic [15:0] d,
                     input logic rd, input logic [15:0] x);
    int n;
    @(negedge clk);
    req_valid = 1; req_op = o; req_addr = a; req_data = d;
    do @(posedge clk); while (req_ready !== 1'b1);
    exp_q.push_back({rd, x});
    @(negedge clk);
    req_valid = 0;
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (done !== 1'b1) check(16'h0000, 16'h0001);
  endtask
  task automatic rd(input logic [19:0] a, input logic [15:0] x);
    req(`OP_READ, a, 16'h0000, 1'b1, x);
  endtask
  task automatic wr(input logic [2:0] o, input logic [19:0] a, input logic [15:0] d);
    req(o, a, d, 1'b0, 16'h0000);
  endtask
  // A write must have raised its busy flag and dropped it again before done.
  always @(posedge clk) begin
    if (wbusy === 1'b1) wb_seen <= 1'b1;
    if (done === 1'b1) begin
      wb_seen <= 1'b0;
      if (exp_q.size() == 0) check(16'h0000, 16'h0001);
      else begin
        e = exp_q.pop_front();
        if (e[16]) check(rd_data, e[15:0]);
        else check({13'h0000, wbusy, wb_seen, busy_n}, 16'h0003);
      end
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    rst = 1; req_valid = 0; req_op = 3'h0; req_addr = 20'h00000; req_data = 16'h0000;
    last_dq = 16'h0000; fail_count = 0; checked = 0; cycles = 0; r = 32'h45EA;
    wb_seen = 1'b0;
    repeat (20) @(posedge clk);
    @(negedge clk) rst = 0;
    check({15'h0000, ce_n & we_n & oe_n & dq_oe_n}, 16'h0001);
    for (int i = 0; i < 2; i++) begin
      r = lfsr(r);
      sa = {r[19:15], 1'b0, r[23:20], 10'h000};
      r = lfsr(r);
      d1 = r[15:0];
      d2 = r[31:16];
      r = lfsr(r);
      d3 = r[15:0];
      rd(sa + 20'h00001, 16'hFFFF);
      wr(`OP_PROGRAM, sa + 20'h00001, d1);
      wr(`OP_PROGRAM, sa + 20'h00400, d2);
      wr(`OP_PROGRAM, sa + 20'h08000, d3);
      rd(sa + 20'h00001, d1);
      wr(`OP_SECTOR_ERS, sa, 16'h0000);
      rd(sa + 20'h00001, 16'hFFFF);
      rd(sa + 20'h00400, d2);
      wr(`OP_BLOCK_ERS, sa, 16'h0000);
      rd(sa + 20'h00400, 16'hFFFF);
      rd(sa + 20'h08000, d3);
      wr(`OP_CHIP_ERS, 20'h00000, 16'h0000);
      rd(sa + 20'h08000, 16'hFFFF);
      $display("pass %0d finished", i);
    end
    @(negedge clk);
    check({15'h0000, exp_q.size() != 0}, 16'h0000);
    results();
  end
endmodule
`default_nettype wire
